// ### include/htp_cfg.svh
`ifndef HTP_CFG_SVH
`define HTP_CFG_SVH

// register indices; byte address is four times the index
`define HTP_IDX_STATUS 8'h00
`define HTP_IDX_MODE 8'h01
`define HTP_IDX_GO 8'h0c
`define HTP_IDX_NV_FIRST 8'h16
`define HTP_IDX_NV_LAST 8'h1a
`define HTP_IDX_CTRL 8'h1d
`define HTP_IDX_SUPPLY 8'h21

// field positions
`define HTP_BIT_SHORT 0
`define HTP_BIT_THERMAL 1
`define HTP_BIT_DEV_RESET 7
`define HTP_BIT_STANDBY 6
`define HTP_BIT_GO 0

// trigger mode field values
`define HTP_MODE_REG 3'h0
`define HTP_MODE_EDGE 3'h1
`define HTP_MODE_LEVEL 3'h2

// reset values
`define HTP_RST_MODE 3'h0
`define HTP_RST_STANDBY 1'b1
`define HTP_RST_NG 2'h0
`define HTP_RST_NV 40'h00_0000_0000

// noise gate thresholds on the 8-bit drive level, per setting
`define HTP_NG_THR0 8'h00
`define HTP_NG_THR1 8'h05
`define HTP_NG_THR2 8'h0a
`define HTP_NG_THR3 8'h14

// timing
`define HTP_CLK_PERIOD_PS 8000
`define HTP_WDOG_TIME_US 4330

// bus answers
`define HTP_RESP_OKAY 2'h0
`define HTP_RESP_SLVERR 2'h2

`endif

// ### include/htp_pkg.sv
package htp_pkg;

	typedef struct packed {
		logic thermal;
		logic out_short;
		logic reg_short;
		logic brownout;
	} htp_fault_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_got;
		logic [7:0] aw_idx;
		logic w_got;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0] mode;
		logic standby;
		logic dev_reset;
		logic go;
		logic thermal_flag;
		logic short_flag;
		logic [39:0] nv_cfg;
		logic [1:0] ng_level;
		logic [7:0] supply_level;
		logic [1:0] en_sync;
		logic [1:0] trig_sync;
		logic trig_prev;
		htp_fault_t fault_s1;
		htp_fault_t fault_s2;
		logic restore_pend;
		logic [19:0] wdog_cnt;
		logic wdog_rst;
		logic playback_go;
		logic active;
		logic [7:0] drive_out;
	} htp_state_t;

endpackage

// ### rtl/htp_ctrl.sv
//
// Contract
// - writing the launch flag to one starts playback; clearing it cancels.
// - edge mode: trigger pin rising edge sets the launch flag.
// - edge mode: another rising edge while flag high cancels and clears it.
// - edge mode: trigger pin falling edge does nothing.
// - level mode: launch flag follows the trigger pin level.
// - drive levels below the noise-gate threshold are suppressed.
// - supply level register updates continuously during playback.
// - once programmed, non-volatile config restores registers 0x16..0x1A.
// - standby lowers power without resetting registers; wakes quickly.
// - watchdog resets stalled serial protocol after 4.33 ms, not in standby.
// - over-temperature shuts down and sets thermal flag in status.
// - output short latches flag, shuts down, restarts when short gone.
// - regulator short holds device non-functional, then resets to defaults.
// - brownout resets the device, which returns to defaults on recovery.
// - enable low is shutdown keeping registers; high is active.
// - enable low: bus answered but no register read or write.
// - standby bit set after reset; keeps registers and bus alive.
// - setting standby stops playback at once; clearing goes to ready.
// - device reset bit restores defaults, aborts playback, self-clears.
// - mode field 0 register, 1 edge, 2 level trigger.
// - launch flag set by write stays high until sequence done.
// - in pin modes the readable launch flag reflects the pin state; edge mode here toggles it on each rising edge instead.
`timescale 1ns/10ps
`default_nettype none
`include "htp_cfg.svh"

module htp_ctrl #(
	// scaled in ns so the product stays inside a 32-bit int
	parameter int WDOG_CYCLES = (`HTP_WDOG_TIME_US * 1000) / (`HTP_CLK_PERIOD_PS / 1000)
) (
	// clock, reset, freeze
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// axi4-lite write address and data
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// pins
	input wire logic enable_pin,
	input wire logic trigger_input_pin,
	input wire htp_pkg::htp_fault_t fault_in,
	// sequencer
	output logic playback_go,
	input wire logic playback_done,
	// drive path and supply sensing
	input wire logic [7:0] drive_in,
	output logic [7:0] drive_out,
	input wire logic [7:0] supply_sample,
	// non-volatile image
	input wire logic nv_programmed,
	input wire logic [39:0] nv_image,
	// serial protocol watchdog
	input wire logic bus_busy,
	output logic bus_wdog_rst,
	// power state
	output logic power_active
);

	htp_pkg::htp_state_t s_r;
	htp_pkg::htp_state_t s_nxt;

	function automatic logic [31:0] reg_read(input htp_pkg::htp_state_t st, input logic [7:0] idx);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (idx)
			`HTP_IDX_STATUS: begin
				v[`HTP_BIT_THERMAL] = st.thermal_flag;
				v[`HTP_BIT_SHORT] = st.short_flag;
			end
			`HTP_IDX_MODE: begin
				v[`HTP_BIT_DEV_RESET] = st.dev_reset;
				v[`HTP_BIT_STANDBY] = st.standby;
				v[2:0] = st.mode;
			end
			`HTP_IDX_GO: v[`HTP_BIT_GO] = st.go;
			`HTP_IDX_CTRL: v[1:0] = st.ng_level;
			`HTP_IDX_SUPPLY: v[7:0] = st.supply_level;
			default: begin
				if (idx >= `HTP_IDX_NV_FIRST && idx <= `HTP_IDX_NV_LAST) begin
					v[7:0] = st.nv_cfg[8'(idx - `HTP_IDX_NV_FIRST) * 8 +: 8];
				end
			end
		endcase
		return v;
	endfunction

	function automatic logic idx_mapped(input logic [7:0] idx);
		return idx == `HTP_IDX_STATUS || idx == `HTP_IDX_MODE || idx == `HTP_IDX_GO ||
			idx == `HTP_IDX_CTRL || idx == `HTP_IDX_SUPPLY ||
			(idx >= `HTP_IDX_NV_FIRST && idx <= `HTP_IDX_NV_LAST);
	endfunction

	logic en_s;
	logic trig_s;
	logic trig_rise;
	logic hold_reset;
	logic [7:0] ng_thr;

	assign en_s = s_r.en_sync[1];
	assign trig_s = s_r.trig_sync[1];
	assign trig_rise = trig_s && !s_r.trig_prev;
	// regulator short and brownout both hold the logic at defaults
	assign hold_reset = s_r.fault_s2.reg_short || s_r.fault_s2.brownout;

	always_comb begin
		case (s_r.ng_level)
			2'h0: ng_thr = `HTP_NG_THR0;
			2'h1: ng_thr = `HTP_NG_THR1;
			2'h2: ng_thr = `HTP_NG_THR2;
			default: ng_thr = `HTP_NG_THR3;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		// synchronisers: stage one is read only by stage two
		s_nxt.en_sync = {s_r.en_sync[0], enable_pin};
		s_nxt.trig_sync = {s_r.trig_sync[0], trigger_input_pin};
		s_nxt.fault_s1 = fault_in;
		s_nxt.fault_s2 = s_r.fault_s1;
		s_nxt.trig_prev = trig_s;
		s_nxt.wdog_rst = 1'b0;

		// write address and data are taken independently
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_idx = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata[7:0];
			s_nxt.w_lane0 = s_axi_wstrb[0];
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = idx_mapped(s_r.aw_idx) ? `HTP_RESP_OKAY : `HTP_RESP_SLVERR;
			// enable low: acknowledged but the register is untouched
			if (en_s && s_r.w_lane0) begin
				case (s_r.aw_idx)
					`HTP_IDX_STATUS: begin
						if (s_r.w_data[`HTP_BIT_THERMAL]) begin
							s_nxt.thermal_flag = 1'b0;
						end
					end
					`HTP_IDX_MODE: begin
						s_nxt.mode = s_r.w_data[2:0];
						s_nxt.standby = s_r.w_data[`HTP_BIT_STANDBY];
						s_nxt.dev_reset = s_r.w_data[`HTP_BIT_DEV_RESET];
					end
					`HTP_IDX_GO: begin
						// level mode: pin owns the flag
						if (s_r.mode != `HTP_MODE_LEVEL) begin
							s_nxt.go = s_r.w_data[`HTP_BIT_GO];
						end
					end
					`HTP_IDX_CTRL: s_nxt.ng_level = s_r.w_data[1:0];
					`HTP_IDX_SUPPLY: begin
					end
					default: begin
						if (s_r.aw_idx >= `HTP_IDX_NV_FIRST && s_r.aw_idx <= `HTP_IDX_NV_LAST) begin
							s_nxt.nv_cfg[8'(s_r.aw_idx - `HTP_IDX_NV_FIRST) * 8 +: 8] = s_r.w_data;
						end
					end
				endcase
			end
		end
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

		// read channel: one outstanding read
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = idx_mapped(s_axi_araddr[9:2]) ? `HTP_RESP_OKAY : `HTP_RESP_SLVERR;
			s_nxt.rdata = en_s ? reg_read(s_r, s_axi_araddr[9:2]) : 32'h0000_0000;
		end
		s_nxt.arready = !s_nxt.rvalid;

		// trigger sources
		case (s_r.mode)
			`HTP_MODE_EDGE: begin
				// falling edge ignored so a short pulse fires any length
				if (trig_rise) begin
					s_nxt.go = !s_r.go;
				end
			end
			`HTP_MODE_LEVEL: s_nxt.go = trig_s;
			default: begin
			end
		endcase
		// a finished sequence drops the flag in register and edge modes
		if (playback_done && s_r.playback_go && s_r.mode != `HTP_MODE_LEVEL) begin
			s_nxt.go = 1'b0;
		end

		// thermal flag: hardware set wins over the software clear
		if (s_r.fault_s2.thermal) begin
			s_nxt.thermal_flag = 1'b1;
			s_nxt.go = 1'b0;
		end
		// short only sensed while driving; flag drops once short clears
		if (s_r.fault_s2.out_short && s_r.playback_go) begin
			s_nxt.short_flag = 1'b1;
			s_nxt.go = 1'b0;
		end else if (s_r.short_flag && !s_r.fault_s2.out_short) begin
			s_nxt.short_flag = 1'b0;
			s_nxt.go = 1'b0;
		end
		if (s_nxt.standby) begin
			s_nxt.go = 1'b0;
		end

		// supply reading tracks only while playing
		if (s_r.playback_go) begin
			s_nxt.supply_level = supply_sample;
		end

		// watchdog on a stalled transfer; disarmed in standby
		if (s_r.standby || !bus_busy) begin
			s_nxt.wdog_cnt = 20'h0_0000;
		end else if (s_r.wdog_cnt == 20'(WDOG_CYCLES - 1)) begin
			s_nxt.wdog_cnt = 20'h0_0000;
			s_nxt.wdog_rst = 1'b1;
		end else begin
			s_nxt.wdog_cnt = s_r.wdog_cnt + 20'h0_0001;
		end

		// restore retained config after any reset
		if (s_r.restore_pend && !hold_reset) begin
			s_nxt.restore_pend = 1'b0;
			if (nv_programmed) begin
				s_nxt.nv_cfg = nv_image;
			end
		end

		// software reset and supply faults act like a power cycle
		if (s_r.dev_reset || hold_reset) begin
			s_nxt.mode = `HTP_RST_MODE;
			s_nxt.standby = `HTP_RST_STANDBY;
			s_nxt.dev_reset = 1'b0;
			s_nxt.go = 1'b0;
			s_nxt.thermal_flag = 1'b0;
			s_nxt.short_flag = 1'b0;
			s_nxt.ng_level = `HTP_RST_NG;
			s_nxt.nv_cfg = `HTP_RST_NV;
			s_nxt.supply_level = 8'h00;
			s_nxt.restore_pend = 1'b1;
		end

		// enable low keeps every register, standby all but the launch flag it clears; only drive stops
		s_nxt.active = en_s && !s_nxt.standby && !hold_reset && !s_r.fault_s2.thermal &&
			!s_nxt.short_flag;
		s_nxt.playback_go = s_nxt.go && s_nxt.active;
		if (!s_nxt.active || drive_in < ng_thr) begin
			s_nxt.drive_out = 8'h00;
		end else begin
			s_nxt.drive_out = drive_in;
		end

		if (!ce) begin
			s_nxt = s_r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.standby <= `HTP_RST_STANDBY;
			s_r.mode <= `HTP_RST_MODE;
			s_r.ng_level <= `HTP_RST_NG;
			s_r.nv_cfg <= `HTP_RST_NV;
			s_r.restore_pend <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign playback_go = s_r.playback_go;
	assign drive_out = s_r.drive_out;
	assign bus_wdog_rst = s_r.wdog_rst;
	assign power_active = s_r.active;

endmodule
`default_nettype wire

// ### testbench/htp_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none
module htp_ctrl_props #(
	parameter int WDOG_CYCLES = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins and side signals
	input wire logic enable_pin,
	input wire logic bus_busy,
	input wire logic bus_wdog_rst,
	input wire logic [7:0] drive_in,
	input wire logic [7:0] drive_out,
	input wire logic playback_go,
	input wire logic power_active,
	// register bus
	input wire logic s_axi_awready,
	input wire logic s_axi_arready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	logic [31:0] busy_cnt_r;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// our count never trails the design's by more than one, hence the slack of two
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			busy_cnt_r <= 32'h0;
		else
			busy_cnt_r <= (bus_busy && !bus_wdog_rst) ? busy_cnt_r + 32'h1 : 32'h0;
	end
	AST_WDOG_ONE: assert property (bus_wdog_rst |=> !bus_wdog_rst)
		else $error("watchdog pulse too long");
	AST_WDOG_CNT: assert property (bus_wdog_rst |-> busy_cnt_r + 32'h2 >= WDOG_CYCLES)
		else $error("watchdog fired early");
	AST_DRV_PASS: assert property (drive_out != 8'h00 |-> drive_out == $past(drive_in))
		else $error("drive level altered");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_AW_WAIT: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during answer");
	AST_AR_WAIT: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during answer");
	AST_OFF_STOP: assert property ($fell(power_active) |=> !playback_go)
		else $error("playback outlives power");
	AST_EN_OFF: assert property (!enable_pin [*5] |-> !power_active)
		else $error("active with enable low");
endmodule
bind htp_ctrl htp_ctrl_props #(.WDOG_CYCLES(WDOG_CYCLES)) i_htp_ctrl_props (
	.clk(clk),
	.rst(rst),
	.enable_pin(enable_pin),
	.bus_busy(bus_busy),
	.bus_wdog_rst(bus_wdog_rst),
	.drive_in(drive_in),
	.drive_out(drive_out),
	.playback_go(playback_go),
	.power_active(power_active),
	.s_axi_awready(s_axi_awready),
	.s_axi_arready(s_axi_arready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

// ### testbench/htp_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module htp_seq_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// sequencer side
	input wire logic playback_go,
	input wire logic [15:0] dur,
	output logic playback_done
);
	logic [15:0] cnt_r;
	// done is a one-cycle pulse; a cancelled run restarts from zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 16'h0;
			playback_done <= 1'b0;
		end else begin
			playback_done <= playback_go && cnt_r == dur;
			cnt_r <= (playback_go && cnt_r != dur) ? cnt_r + 16'h1 : 16'h0;
		end
	end
endmodule
`default_nettype wire

// ### testbench/htp_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module htp_ctrl_tb;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, enable_pin = 1'b1, trigger_input_pin = 1'b0;
	logic playback_done, playback_go, bus_busy = 1'b0, bus_wdog_rst, power_active, nv_programmed = 1'b1;
	logic s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_arready, s_axi_rvalid, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] drive_in = 8'h00, drive_out, supply_sample = 8'h5a;
	logic [39:0] nv_image = 40'h1a_2b_3c_4d_5e;
	logic [15:0] dur = 16'h0014;
	htp_pkg::htp_fault_t fault_in = 4'h0;
	int mismatches = 0, n_checks = 0;
	always #4 clk = ~clk;
	htp_ctrl #(.WDOG_CYCLES(20)) i_htp_ctrl (.*);
	htp_seq_model i_htp_seq_model (.*);
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task tmo(input int i);
		if (i > 80) begin
			chk("timeout", 32'h0, 32'h1);
			print_verdict;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a, w;
		a = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int i = 0; !(a && w); i++) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) begin
				a = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
			tmo(i);
		end
		s_axi_bready <= 1'b1;
		for (int i = 0; s_axi_bvalid !== 1'b1 || i == 0; i++) begin
			@(posedge clk);
			tmo(i);
		end
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task rdc(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		for (int i = 0; !(s_axi_arvalid && s_axi_arready) || i == 0; i++) begin
			@(posedge clk);
			tmo(i);
		end
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		for (int i = 0; s_axi_rvalid !== 1'b1 || i == 0; i++) begin
			@(posedge clk);
			tmo(i);
		end
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, {24'h0, ed});
		chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	task wgo(input logic v);
		for (int i = 0; playback_go !== v; i++) begin
			@(posedge clk);
			tmo(i);
		end
		chk("playback_go", {31'h0, playback_go}, {31'h0, v});
	endtask
	task t_reset;
		rdc(8'h01, 8'h40, 2'h0);
		rdc(8'h16, 8'h5e, 2'h0);
		rdc(8'h1a, 8'h1a, 2'h0);
		rdc(8'h3f, 8'h00, 2'h2);
		wr(8'h3f, 8'hff, 2'h2);
	endtask
	task t_reg_trig;
		wr(8'h1d, 8'h03, 2'h0);
		wr(8'h01, 8'h00, 2'h0);
		cyc(3);
		chk("power_active", {31'h0, power_active}, 32'h1);
		drive_in <= 8'h13;
		cyc(3);
		chk("drive_out", {24'h0, drive_out}, 32'h0);
		drive_in <= 8'h14;
		cyc(3);
		chk("drive_out", {24'h0, drive_out}, 32'h14);
		wr(8'h0c, 8'h01, 2'h0);
		wgo(1'b1);
		rdc(8'h0c, 8'h01, 2'h0);
		rdc(8'h21, 8'h5a, 2'h0);
		wgo(1'b0);
		rdc(8'h0c, 8'h00, 2'h0);
		dur <= 16'h0400;
		wr(8'h0c, 8'h01, 2'h0);
		wgo(1'b1);
		wr(8'h0c, 8'h00, 2'h0);
		wgo(1'b0);
	endtask
	task t_edge;
		wr(8'h01, 8'h01, 2'h0);
		trigger_input_pin <= 1'b1;
		cyc(2);
		trigger_input_pin <= 1'b0;
		wgo(1'b1);
		cyc(10);
		chk("playback_go", {31'h0, playback_go}, 32'h1);
		rdc(8'h0c, 8'h01, 2'h0);
		trigger_input_pin <= 1'b1;
		wgo(1'b0);
		trigger_input_pin <= 1'b0;
		cyc(4);
		rdc(8'h0c, 8'h00, 2'h0);
	endtask
	task t_level;
		wr(8'h01, 8'h02, 2'h0);
		trigger_input_pin <= 1'b1;
		wgo(1'b1);
		rdc(8'h0c, 8'h01, 2'h0);
		// clock enable low must freeze the flag despite the pin falling
		ce <= 1'b0;
		trigger_input_pin <= 1'b0;
		cyc(6);
		chk("playback_go", {31'h0, playback_go}, 32'h1);
		ce <= 1'b1;
		wgo(1'b0);
	endtask
	task t_standby;
		wr(8'h01, 8'h00, 2'h0);
		wr(8'h0c, 8'h01, 2'h0);
		wgo(1'b1);
		wr(8'h01, 8'h40, 2'h0);
		chk("playback_go", {31'h0, playback_go}, 32'h0);
		rdc(8'h1d, 8'h03, 2'h0);
	endtask
	task t_wdog;
		int n;
		n = 0;
		bus_busy <= 1'b1;
		repeat (30) begin
			@(posedge clk);
			n += int'(bus_wdog_rst);
		end
		chk("wdog_standby", n, 0);
		wr(8'h01, 8'h00, 2'h0);
		n = 0;
		repeat (30) begin
			@(posedge clk);
			n += int'(bus_wdog_rst);
		end
		bus_busy <= 1'b0;
		chk("wdog_pulses", n, 1);
	endtask
	task t_enable;
		enable_pin <= 1'b0;
		cyc(5);
		chk("power_active", {31'h0, power_active}, 32'h0);
		rdc(8'h1d, 8'h00, 2'h0);
		wr(8'h1d, 8'h01, 2'h0);
		enable_pin <= 1'b1;
		cyc(4);
		rdc(8'h1d, 8'h03, 2'h0);
	endtask
	task t_faults;
		wr(8'h01, 8'h00, 2'h0);
		cyc(3);
		chk("power_active", {31'h0, power_active}, 32'h1);
		fault_in <= 4'h8;
		cyc(4);
		chk("power_active", {31'h0, power_active}, 32'h0);
		rdc(8'h00, 8'h02, 2'h0);
		// the synchronised fault must be gone or its set beats the clear
		fault_in <= 4'h0;
		cyc(3);
		wr(8'h00, 8'h02, 2'h0);
		rdc(8'h00, 8'h00, 2'h0);
		wr(8'h0c, 8'h01, 2'h0);
		wgo(1'b1);
		fault_in <= 4'h4;
		wgo(1'b0);
		rdc(8'h00, 8'h01, 2'h0);
		fault_in <= 4'h0;
		cyc(4);
		rdc(8'h00, 8'h00, 2'h0);
		rdc(8'h0c, 8'h00, 2'h0);
		wr(8'h1d, 8'h02, 2'h0);
		wr(8'h16, 8'h77, 2'h0);
		rdc(8'h16, 8'h77, 2'h0);
		fault_in <= 4'h2;
		cyc(4);
		chk("power_active", {31'h0, power_active}, 32'h0);
		fault_in <= 4'h0;
		cyc(4);
		rdc(8'h1d, 8'h00, 2'h0);
		rdc(8'h16, 8'h5e, 2'h0);
		wr(8'h01, 8'h00, 2'h0);
		wr(8'h1d, 8'h02, 2'h0);
		wr(8'h16, 8'h77, 2'h0);
		fault_in <= 4'h1;
		cyc(4);
		fault_in <= 4'h0;
		cyc(4);
		rdc(8'h1d, 8'h00, 2'h0);
		rdc(8'h16, 8'h5e, 2'h0);
		rdc(8'h01, 8'h40, 2'h0);
	endtask
	task t_dev_reset;
		wr(8'h1d, 8'h02, 2'h0);
		wr(8'h01, 8'h80, 2'h0);
		rdc(8'h1d, 8'h00, 2'h0);
		rdc(8'h01, 8'h40, 2'h0);
	endtask
	initial begin
		cyc(20);
		rst <= 1'b0;
		cyc(3);
		t_reset;
		t_reg_trig;
		t_edge;
		t_level;
		t_standby;
		t_wdog;
		t_enable;
		t_dev_reset;
		t_faults;
		print_verdict;
	end
endmodule
`default_nettype wire
